// *** src/lassq_sequencer.sv ***
// Purpose: scan sequencer of a 128-pixel linear array readout
// Assumes: scanStart and scanClkEn synchronous to clk; scanClkEn marks one array clock
// Notes: no reset pin on the real array; srst models power-up only

`timescale 1ns/10ps
module lassq_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // array control pins
  input wire logic scanStart,
  input wire logic scanClkEn,
  // light levels seen by the pixels
  input wire logic [lassq_pkg::PIXELS*lassq_pkg::SAMPLE_W-1:0] pixelLevel,
  // analog output model
  output lassq_pkg::lassq_sample_type analog_pixel_output,
  output logic analogOutOeN,
  // status
  output logic integrating,
  output logic integratorReset,
  output logic scanTrusted
);
  typedef enum logic [1:0] {IDLE, SHIFT, REINIT} lassq_phase_type;

  typedef struct packed {
    lassq_phase_type phase;
    logic [lassq_pkg::STAGES-1:0] shiftReg;
    logic [lassq_pkg::CNT_W-1:0] clkCount;
    logic intReset;
    logic integ;
    logic primed;
    logic trusted;
    lassq_pkg::lassq_out_type out;
  } lassq_state_type;

  lassq_state_type state_q, state_d;
  logic freeze;
  logic [7:0] selIndex;
  lassq_pkg::lassq_sample_type selSample;

  assign freeze = scanClkEn && scanStart;
  // the two leading dummies shift the pixel index down by two
  // slots outside the pixel range read junk, but nothing latches it then
  assign selIndex = 8'(state_q.clkCount - 8'(lassq_pkg::LEAD_DUMMIES));

  lassq_hold_bank u_hold (
    .clk(clk),
    .srst(srst),
    .freeze(freeze),
    .integReset(state_q.intReset),
    .pixelLevel(pixelLevel),
    .selIndex(selIndex),
    .selSample(selSample)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (scanClkEn) begin
      state_d.shiftReg = {state_q.shiftReg[lassq_pkg::STAGES-2:0], freeze};
      if (freeze) begin
        // a restart mid-readout aborts the running scan
        state_d.phase = SHIFT;
        state_d.clkCount = 8'h01;
        state_d.intReset = 1'b1;
        state_d.integ = 1'b0;
        state_d.trusted = state_q.primed;
        state_d.out.drive = 1'b1;
        state_d.out.valid = 1'b0;
        state_d.out.value = lassq_pkg::DUMMY_SAMPLE;
      end else begin
        case (state_q.phase)
          SHIFT: begin
            state_d.clkCount = 8'(state_q.clkCount + 8'h01);
            if (state_q.clkCount == 8'(lassq_pkg::RESET_CLOCKS - 1)) begin
              state_d.intReset = 1'b0;
              state_d.integ = 1'b1;
            end
            if (state_q.clkCount == 8'(lassq_pkg::STAGES)) begin
              state_d.phase = REINIT;
              state_d.out.drive = 1'b0;
              state_d.out.valid = 1'b0;
              state_d.out.value = lassq_pkg::DUMMY_SAMPLE;
            end else if (state_q.clkCount >= 8'(lassq_pkg::LEAD_DUMMIES)
                         && state_q.clkCount < 8'(lassq_pkg::LEAD_DUMMIES + lassq_pkg::PIXELS)) begin
              state_d.out.valid = 1'b1;
              state_d.out.value = selSample;
            end else begin
              state_d.out.valid = 1'b0;
              state_d.out.value = lassq_pkg::DUMMY_SAMPLE;
            end
          end
          REINIT: begin
            // the 134th clock, counting the start clock as 1, clears the register for the next scan
            state_d.phase = IDLE;
            state_d.clkCount = lassq_pkg::CNT_RESET;
            state_d.shiftReg = '0;
            state_d.primed = 1'b1;
          end
          IDLE: begin
            state_d.clkCount = lassq_pkg::CNT_RESET;
          end
          default: begin
            state_d.phase = IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.phase <= IDLE;
      state_q.intReset <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign analog_pixel_output = state_q.out.value;
  assign analogOutOeN = !state_q.out.drive;
  assign integrating = state_q.integ;
  assign integratorReset = state_q.intReset;
  assign scanTrusted = state_q.trusted;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_drives: assert property (@(posedge clk) disable iff (srst)
    freeze |=> !analogOutOeN && state_q.clkCount == 8'h01) else $error("start not taken");
  a_shift_step: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && state_q.phase == SHIFT && !freeze |=> state_q.shiftReg[1] == $past(state_q.shiftReg[0]))
    else $error("shift register did not step");
  a_reset_window: assert property (@(posedge clk) disable iff (srst)
    state_q.phase == SHIFT && state_q.clkCount < 8'(lassq_pkg::RESET_CLOCKS) |-> integratorReset)
    else $error("integrator released early");
  a_integ_begin: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && !freeze && state_q.phase == SHIFT && state_q.clkCount == 8'(lassq_pkg::RESET_CLOCKS - 1)
      |=> integrating && !integratorReset)
    else $error("integration did not begin at clock 18");
  a_integ_ends: assert property (@(posedge clk) disable iff (srst)
    freeze |=> !integrating) else $error("integration not ended by start");
  a_release_out: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && !freeze && state_q.phase == SHIFT && state_q.clkCount == 8'(lassq_pkg::STAGES) |=> analogOutOeN)
    else $error("output not released after 132 samples");
  a_dummy_lead: assert property (@(posedge clk) disable iff (srst)
    state_q.phase == SHIFT && state_q.clkCount <= 8'(lassq_pkg::LEAD_DUMMIES) |-> !state_q.out.valid)
    else $error("leading dummy marked as pixel");
  a_reinit_clear: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && !freeze && state_q.phase == REINIT |=> state_q.primed && state_q.shiftReg == '0)
    else $error("register not re-initialised");
  a_first_scan: assert property (@(posedge clk) disable iff (srst)
    freeze && !state_q.primed |=> !scanTrusted) else $error("first scan marked trusted");

  // ----------------------------------------------------------------
  // sequence and output checks
  // ----------------------------------------------------------------
  // between array clocks nothing may move, whatever scanStart does
  a_hold_idle: assert property (@(posedge clk) disable iff (srst)
    !scanClkEn |=> $stable(state_q)) else $error("state moved without an array clock");
  a_start_bit: assert property (@(posedge clk) disable iff (srst)
    freeze |=> state_q.shiftReg[0]) else $error("start bit not captured");
  // complementary flags keep one shared window for every pixel
  a_window_pair: assert property (@(posedge clk) disable iff (srst)
    integrating != integratorReset) else $error("integrate and reset flags disagree");

  // pixel slots, then the trailing dummies
  a_pixel_valid: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && !freeze && state_q.phase == SHIFT && state_q.clkCount >= 8'(lassq_pkg::LEAD_DUMMIES)
      && state_q.clkCount < 8'(lassq_pkg::LEAD_DUMMIES + lassq_pkg::PIXELS) |=> state_q.out.valid)
    else $error("pixel slot not marked valid");
  a_trail_dummy: assert property (@(posedge clk) disable iff (srst)
    scanClkEn && !freeze && state_q.phase == SHIFT
      && state_q.clkCount >= 8'(lassq_pkg::LEAD_DUMMIES + lassq_pkg::PIXELS)
      |=> !state_q.out.valid && analog_pixel_output == lassq_pkg::DUMMY_SAMPLE)
    else $error("trailing dummy not blank");
  // a sample must stay put for the controller's slow clock
  a_out_stands: assert property (@(posedge clk) disable iff (srst)
    !scanClkEn |=> $stable(analog_pixel_output) && $stable(analogOutOeN))
    else $error("sample changed between clocks");

  // output driven only while samples shift out
  a_drive_shift: assert property (@(posedge clk) disable iff (srst)
    state_q.phase == SHIFT |-> !analogOutOeN) else $error("output released mid-scan");
  a_float_rest: assert property (@(posedge clk) disable iff (srst)
    state_q.phase != SHIFT |-> analogOutOeN) else $error("output driven outside a scan");

  // the count never outruns one full readout
  a_reinit_count: assert property (@(posedge clk) disable iff (srst)
    state_q.phase == REINIT |-> state_q.clkCount == 8'(lassq_pkg::FULL_CLOCKS))
    else $error("re-init off the last clock");
  a_count_bound: assert property (@(posedge clk) disable iff (srst)
    state_q.clkCount <= 8'(lassq_pkg::FULL_CLOCKS)) else $error("clock count ran past a readout");
  a_trusted_next: assert property (@(posedge clk) disable iff (srst)
    freeze && state_q.primed |=> scanTrusted) else $error("primed scan not trusted");
  c_start: cover property (@(posedge clk) disable iff (srst) freeze);
  c_pixel: cover property (@(posedge clk) disable iff (srst) state_q.out.valid);
  c_reinit: cover property (@(posedge clk) disable iff (srst) state_q.phase == REINIT);
  c_trusted: cover property (@(posedge clk) disable iff (srst) freeze && state_q.primed);
  c_abort: cover property (@(posedge clk) disable iff (srst) freeze && state_q.phase == SHIFT);
endmodule : lassq_sequencer

// *** src/lassq_pkg.sv ***
// Purpose: shared constants and types for the linear array scan sequencer
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes: pixel values are digital stand-ins for the analog samples

package lassq_pkg;
  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int STAGES = 132;
  localparam int PIXELS = 128;
  localparam int LEAD_DUMMIES = 2;
  localparam int FULL_CLOCKS = 133;
  localparam int RESET_CLOCKS = 18;
  localparam int SAMPLE_W = 8;
  localparam int CNT_W = 8;
  localparam logic [SAMPLE_W-1:0] DUMMY_SAMPLE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

  typedef logic [SAMPLE_W-1:0] lassq_sample_type;

  typedef struct packed {
    logic valid;
    logic drive;
    lassq_sample_type value;
  } lassq_out_type;
endpackage : lassq_pkg

// *** src/lassq_hold_bank.sv ***
// Purpose: sample-and-hold bank, all pixels frozen at one instant
// Assumes: freeze is a one-cycle pulse from the sequencer
// Notes: one generate entry per pixel

`timescale 1ns/10ps
module lassq_hold_bank (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic freeze,
  input wire logic integReset,
  // pixel levels
  input wire logic [lassq_pkg::PIXELS*lassq_pkg::SAMPLE_W-1:0] pixelLevel,
  input wire logic [7:0] selIndex,
  output lassq_pkg::lassq_sample_type selSample
);
  lassq_pkg::lassq_sample_type held [lassq_pkg::PIXELS];

  // ----------------------------------------------------------------
  // per pixel hold
  // ----------------------------------------------------------------
  for (genvar i = 0; i < lassq_pkg::PIXELS; i++) begin : g_pix
    always_ff @(posedge clk) begin
      if (srst) begin
        held[i] <= lassq_pkg::DUMMY_SAMPLE;
      end else if (freeze) begin
        // a common strobe gives every pixel the same window
        held[i] <= integReset ? lassq_pkg::DUMMY_SAMPLE
                              : pixelLevel[i*lassq_pkg::SAMPLE_W +: lassq_pkg::SAMPLE_W];
      end
    end
  end

  assign selSample = held[selIndex[6:0]];
endmodule : lassq_hold_bank

// *** test/lassq_ctl_model.sv ***
// Purpose: scan controller model driving start bit and array clock
// Assumes: tb calls the tasks; one clk domain
// Notes: array clock is a one-cycle enable, still between calls
`timescale 1ns/10ps
module lassq_ctl_model (
  // clock
  input wire logic clk,
  // array control pins
  output logic scanStart,
  output logic scanClkEn
);
  initial begin
    scanStart = 1'b0;
    scanClkEn = 1'b0;
  end
  // one array clock, optionally with the start bit
  task automatic tick(input logic withStart);
    @(posedge clk);
    #1 scanStart = withStart;
    scanClkEn = 1'b1;
    @(posedge clk);
    #1 scanStart = 1'b0;
    scanClkEn = 1'b0;
  endtask : tick
  // start level without a clock, must be ignored
  task automatic stray();
    @(posedge clk);
    #1 scanStart = 1'b1;
    @(posedge clk);
    #1 scanStart = 1'b0;
  endtask : stray
  // 10 us hold settle; integration stays far below 2 ms
  task automatic settle();
    repeat (2500) @(posedge clk);
  endtask : settle
endmodule : lassq_ctl_model

// *** test/tb.sv ***
// Purpose: self-checking bench of the scan sequencer
// Assumes: 250 MHz clk, srst held 6 cycles
// Notes: samples taken 1 ns after the enable edge
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scanStart;
  logic scanClkEn;
  logic [lassq_pkg::PIXELS*lassq_pkg::SAMPLE_W-1:0] pixelLevel = '0;
  lassq_pkg::lassq_sample_type aOut;
  logic oeN;
  logic integ;
  logic integRst;
  logic trusted;
  int miscompares = 0;
  int totalChecks = 0;
  always #2 clk = ~clk;
  lassq_ctl_model ctl (.clk(clk), .scanStart(scanStart), .scanClkEn(scanClkEn));
  lassq_sequencer uut (.clk(clk), .srst(srst), .scanStart(scanStart), .scanClkEn(scanClkEn),
    .pixelLevel(pixelLevel), .analog_pixel_output(aOut), .analogOutOeN(oeN),
    .integrating(integ), .integratorReset(integRst), .scanTrusted(trusted));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] pix(input int i);
    return 8'h20 + i[7:0];
  endfunction : pix
  task automatic flags(input logic [2:0] exp);
    check("oeN", {7'h00, oeN}, {7'h00, exp[2]});
    check("integrating", {7'h00, integ}, {7'h00, exp[1]});
    check("intReset", {7'h00, integRst}, {7'h00, exp[0]});
  endtask : flags
  // start bit, then 133 clocks, every sample judged
  task automatic walk(input logic lit);
    int k;
    ctl.tick(1'b1);
    check("sample", aOut, 8'h00);
    flags(3'h1);
    for (k = 1; k <= lassq_pkg::FULL_CLOCKS; k++) begin
      ctl.tick(1'b0);
      check("sample", aOut, (lit && k >= 2 && k <= 129) ? pix(k - 2) : 8'h00);
      flags({k >= 132, k >= 17, k < 17});
    end
  endtask : walk
  task automatic resetState();
    check("sample", aOut, 8'h00);
    flags(3'h5);
    check("trusted", {7'h00, trusted}, 8'h00);
  endtask : resetState
  task automatic strayStart();
    ctl.stray();
    repeat (3) ctl.tick(1'b0);
    flags(3'h5);
  endtask : strayStart
  task automatic firstScan();
    walk(1'b0);
    check("trusted", {7'h00, trusted}, 8'h00);
  endtask : firstScan
  task automatic secondScan();
    ctl.settle();
    walk(1'b1);
    check("trusted", {7'h00, trusted}, 8'h01);
  endtask : secondScan
  // restart mid-scan while integrating
  task automatic abortScan();
    ctl.settle();
    ctl.tick(1'b1);
    repeat (20) ctl.tick(1'b0);
    walk(1'b1);
  endtask : abortScan
  task automatic wrapUp();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrapUp
  initial begin
    for (int i = 0; i < lassq_pkg::PIXELS; i++) begin
      pixelLevel[8*i +: 8] = pix(i);
    end
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    resetState();
    strayStart();
    firstScan();
    secondScan();
    abortScan();
    wrapUp();
  end
endmodule : tb
